// ==== logic/pll_fractional_feedback_divider.sv ====
/*
 * Frequency translation control for the first synthesizer loop: byte-wide
 * shadow registers on an Avalon-MM slave, an update strobe that moves them
 * to the active set, mode and range decode, and the sigma-delta feedback
 * division.
 * Assumes an Avalon-MM master on sys_clk_in and a same-clock pulse that
 * marks each completed feedback division.
 */
`default_nettype none

// Contract
// RQ1: predivider 4..4095 divides reference by value
// RQ2: predivider 0 doubles, 1..3 bypass
// RQ3: integer part is one 8-bit register
// RQ4: legal integer range depends on mode
// RQ5: integer-N mode needs integer 15..255
// RQ6: fractional-N mode needs integer 80..255
// RQ7: fraction is 20 bits over three registers
// RQ8: zero fraction selects integer, modulator off
// RQ9: nonzero fraction runs the modulator
// RQ10: modulus is 20 bits over three registers
// RQ11: software keeps modulus above fraction
// RQ12: secondary divider low byte own register
// RQ13: secondary 0..1 bypass, 2..3 undefined
// RQ14: writing update bit applies new settings
// RQ15: average division equals integer plus fraction
// RQ16: unused upper bits read zero
module pll_fractional_feedback_divider (
    // Clock and reset
    input  wire logic                          sys_clk_in,
    input  wire logic                          rstn_in,
    // Avalon-MM slave
    input  wire logic [fdiv_pkg::ADDR_W-1:0]   address_in,
    input  wire logic                          read_in,
    input  wire logic                          write_in,
    input  wire logic [3:0]                    byteenable_in,
    input  wire logic [fdiv_pkg::DATA_W-1:0]   writedata_in,
    output var  logic [fdiv_pkg::DATA_W-1:0]   readdata_out,
    output logic                               waitrequest_out,
    // Feedback divider step
    input  wire logic                          fb_step_in,
    // Reference predivider
    output var  fdiv_pkg::ref_mode_t           ref_mode_out,
    output var  logic [fdiv_pkg::REFDIV_W-1:0] ref_divisor_out,
    // Primary feedback divider
    output var  logic                          sdm_enable_out,
    output var  logic                          int_legal_out,
    output var  logic [fdiv_pkg::INT_W:0]      feedback_n_out,
    // Secondary feedback divider
    output var  fdiv_pkg::sec_mode_t           sec_mode_out,
    output var  logic [fdiv_pkg::SECDIV_W-1:0] sec_divisor_out,
    output var  logic                          loop2_allowed_out,
    // Update strobe
    output var  logic                          update_out
);

    import fdiv_pkg::*;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    // ************************************************************
    // Decode helpers
    // ************************************************************
    function automatic logic hit(input logic             fire,
                                 input logic [IDX_W-1:0] at,
                                 input logic [IDX_W-1:0] target);
        return fire && (at == target);
    endfunction
    function automatic ref_mode_t ref_decode(input logic [REFDIV_W-1:0] v);
        if (v == REF_DOUBLE_VAL) return REF_DOUBLE;
        if (v <= REF_BYPASS_MAX) return REF_BYPASS;
        return REF_DIVIDE;
    endfunction
    function automatic sec_mode_t sec_decode(input logic [SECDIV_W-1:0] v);
        if (v <= SEC_BYPASS_MAX) return SEC_BYPASS;
        if (v <= SEC_UNDEF_MAX) return SEC_UNDEFINED;
        return SEC_DIVIDE;
    endfunction
    // RQ5 RQ6: mode lower bounds
    function automatic logic int_ok(input logic [INT_W-1:0] n,
                                    input logic             frac_mode);
        return frac_mode ? (n >= INT_MIN_FRACN) : (n >= INT_MIN_INTN);
    endfunction

    // ************************************************************
    // Bus slave
    // ************************************************************
    logic              ack;
    logic [IDX_W-1:0]  idx;
    logic [BYTE_W-1:0] wbyte;
    logic              wr_fire;
    logic              load;
    logic [BYTE_W-1:0] rd_mux;

    assign idx   = address_in[ADDR_W-1:2];
    assign wbyte = writedata_in[BYTE_W-1:0];

    // Every access waits exactly one cycle, so the answer is fixed.
    assign waitrequest_out = (read_in || write_in) && !ack;
    assign wr_fire         = write_in && ack && byteenable_in[0];

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ack <= 1'b0;
        end else begin
            ack <= (read_in || write_in) && !ack;
        end
    end

    // ************************************************************
    // Shadow registers
    // ************************************************************
    logic [REFDIV_W-1:0] ref_sh;
    logic [INT_W-1:0]    int_sh;
    logic [FRAC_W-1:0]   frac_sh;
    logic [FRAC_W-1:0]   mod_sh;
    logic [SECDIV_W-1:0] sec_sh;

    // RQ1: predivider field write
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ref_sh <= REF_DIV_RST;
        end else begin
            if (hit(wr_fire, idx, IDX_REF_LOW)) ref_sh[7:0] <= wbyte;
            if (hit(wr_fire, idx, IDX_REF_HIGH)) ref_sh[11:8] <= wbyte[3:0];
        end
    end

    // RQ3: whole-byte integer part
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            int_sh <= INT_RST;
        end else if (hit(wr_fire, idx, IDX_INT)) begin
            int_sh <= wbyte;
        end
    end

    // RQ7: fraction from three bytes
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            frac_sh <= FRAC_RST;
        end else begin
            if (hit(wr_fire, idx, IDX_FRAC_LOW)) frac_sh[7:0] <= wbyte;
            if (hit(wr_fire, idx, IDX_FRAC_MID)) frac_sh[15:8] <= wbyte;
            if (hit(wr_fire, idx, IDX_FRAC_HIGH)) begin
                frac_sh[19:16] <= wbyte[3:0];
            end
        end
    end

    // RQ10: modulus from three bytes
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mod_sh <= MOD_RST;
        end else begin
            if (hit(wr_fire, idx, IDX_MOD_LOW)) mod_sh[7:0] <= wbyte;
            if (hit(wr_fire, idx, IDX_MOD_MID)) mod_sh[15:8] <= wbyte;
            if (hit(wr_fire, idx, IDX_MOD_HIGH)) begin
                mod_sh[19:16] <= wbyte[3:0];
            end
        end
    end

    // RQ12: secondary low byte apart
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sec_sh <= SEC_DIV_RST;
        end else begin
            if (hit(wr_fire, idx, IDX_SEC_LOW)) sec_sh[7:0] <= wbyte;
            if (hit(wr_fire, idx, IDX_SEC_HIGH)) sec_sh[11:8] <= wbyte[3:0];
        end
    end

    // ************************************************************
    // Update strobe and active settings
    // ************************************************************
    logic [INT_W-1:0]  int_act;
    logic [FRAC_W-1:0] frac_act;
    logic [FRAC_W-1:0] mod_act;
    logic              mod_ok;

    // RQ14: update bit loads settings
    assign load = hit(wr_fire, idx, IDX_UPDATE) && wbyte[UPDATE_BIT];

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            update_out <= 1'b0;
        end else begin
            update_out <= load;
        end
    end

    // RQ1: divisor and mode decode
    // RQ2: double or bypass decode
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ref_divisor_out <= REF_DIV_RST;
            ref_mode_out    <= ref_decode(REF_DIV_RST);
        end else if (load) begin
            ref_divisor_out <= ref_sh;
            ref_mode_out    <= ref_decode(ref_sh);
        end
    end

    // RQ8: zero fraction integer mode
    // RQ9: nonzero fraction runs modulator
    // RQ4: mode dependent range check
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            int_act        <= INT_RST;
            frac_act       <= FRAC_RST;
            mod_act        <= MOD_RST;
            sdm_enable_out <= (FRAC_RST != '0);
            int_legal_out  <= int_ok(INT_RST, FRAC_RST != '0);
            mod_ok         <= (MOD_RST > FRAC_RST);
        end else if (load) begin
            int_act        <= int_sh;
            frac_act       <= frac_sh;
            mod_act        <= mod_sh;
            sdm_enable_out <= (frac_sh != '0);
            int_legal_out  <= int_ok(int_sh, frac_sh != '0);
            mod_ok         <= (mod_sh > frac_sh);
        end
    end

    // RQ13: secondary divider decode
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sec_divisor_out   <= SEC_DIV_RST;
            sec_mode_out      <= sec_decode(SEC_DIV_RST);
            loop2_allowed_out <= (SEC_DIV_RST > SEC_BYPASS_MAX);
        end else if (load) begin
            sec_divisor_out   <= sec_sh;
            sec_mode_out      <= sec_decode(sec_sh);
            loop2_allowed_out <= (sec_sh > SEC_BYPASS_MAX);
        end
    end

    // ************************************************************
    // Sigma-delta modulator
    // ************************************************************
    // RQ11: modulus above fraction assumed
    // The modulator restarts for one cycle after each update so that an
    // old accumulator is never compared against a new, smaller modulus.
    sigma_delta_acc #(
        .INT_W  (INT_W),
        .FRAC_W (FRAC_W)
    ) u_sdm (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .run_in     (sdm_enable_out && !update_out),
        .step_in    (fb_step_in),
        .int_in     (int_act),
        .frac_in    (frac_act),
        .mod_in     (mod_act),
        .n_out      (feedback_n_out),
        .carry_out  ()
    );

    // ************************************************************
    // Readback
    // ************************************************************
    // RQ16: upper nibbles read zero
    always_comb begin
        rd_mux = '0;
        unique case (idx)
            IDX_REF_LOW:   rd_mux = ref_sh[7:0];
            IDX_REF_HIGH:  rd_mux = {4'h0, ref_sh[11:8]};
            IDX_INT:       rd_mux = int_sh;
            IDX_FRAC_LOW:  rd_mux = frac_sh[7:0];
            IDX_FRAC_MID:  rd_mux = frac_sh[15:8];
            IDX_FRAC_HIGH: rd_mux = {4'h0, frac_sh[19:16]};
            IDX_MOD_LOW:   rd_mux = mod_sh[7:0];
            IDX_MOD_MID:   rd_mux = mod_sh[15:8];
            IDX_MOD_HIGH:  rd_mux = {4'h0, mod_sh[19:16]};
            IDX_SEC_LOW:   rd_mux = sec_sh[7:0];
            IDX_SEC_HIGH:  rd_mux = {4'h0, sec_sh[11:8]};
            IDX_STATUS: begin
                rd_mux[STAT_FRAC_BIT]   = sdm_enable_out;
                rd_mux[STAT_INT_OK_BIT] = int_legal_out;
                rd_mux[STAT_MOD_OK_BIT] = mod_ok;
                rd_mux[STAT_LOOP2_BIT]  = loop2_allowed_out;
            end
            default:       rd_mux = '0;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            readdata_out <= '0;
        end else if (read_in && !ack) begin
            readdata_out <= {{(DATA_W - BYTE_W){1'b0}}, rd_mux};
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_bus_answer: assert property (
        (read_in || write_in) |-> ##[0:1] !waitrequest_out)
        else $error("bus access not answered within one cycle");
    a_ref_divide: assert property ( // RQ1
        ref_divisor_out >= 12'h004 |-> ref_mode_out == REF_DIVIDE)
        else $error("predivider 4..4095 not dividing");
    a_ref_low_modes: assert property ( // RQ2
        ref_divisor_out < 12'h004 |->
        ref_mode_out == ((ref_divisor_out == 12'h000) ? REF_DOUBLE
                                                      : REF_BYPASS))
        else $error("predivider 0..3 decoded wrongly");
    a_int_write: assert property ( // RQ3
        hit(wr_fire, idx, IDX_INT) |=> int_sh == $past(wbyte))
        else $error("integer part write lost");
    a_int_range: assert property ( // RQ4
        $past(load) |-> int_legal_out ==
        ($past(frac_sh) != '0 ? $past(int_sh) >= 8'h50
                              : $past(int_sh) >= 8'h0F))
        else $error("integer range flag wrong for mode");
    a_intn_range: assert property ( // RQ5
        !sdm_enable_out && int_act >= 8'h0F |-> int_legal_out)
        else $error("integer-N value 15..255 flagged illegal");
    a_fracn_range: assert property ( // RQ6
        sdm_enable_out && int_act < 8'h50 |-> !int_legal_out)
        else $error("fractional-N value below 80 flagged legal");
    a_frac_high: assert property ( // RQ7
        hit(wr_fire, idx, IDX_FRAC_HIGH) |=>
        frac_sh[19:16] == $past(writedata_in[3:0]) && $stable(frac_sh[15:0]))
        else $error("fraction top nibble not assembled");
    a_int_mode_hold: assert property ( // RQ8
        (!sdm_enable_out && $stable(int_act)) [*2] |->
        feedback_n_out == {1'b0, int_act})
        else $error("integer mode divider not at integer part");
    a_frac_enable: assert property ( // RQ9
        sdm_enable_out == (frac_act != '0))
        else $error("modulator enable does not follow fraction");
    a_mod_high: assert property ( // RQ10
        hit(wr_fire, idx, IDX_MOD_HIGH) |=>
        mod_sh[19:16] == $past(writedata_in[3:0]) && $stable(mod_sh[15:0]))
        else $error("modulus top nibble not assembled");
    a_sec_low: assert property ( // RQ12
        hit(wr_fire, idx, IDX_SEC_LOW) |=>
        sec_sh[7:0] == $past(wbyte) && $stable(sec_sh[11:8]))
        else $error("secondary low byte write wrong");
    a_sec_bypass: assert property ( // RQ13
        sec_divisor_out <= 12'h001 |->
        sec_mode_out == SEC_BYPASS && !loop2_allowed_out)
        else $error("secondary 0..1 not bypassed");
    a_update_apply: assert property ( // RQ14
        load |=> update_out && int_act == $past(int_sh) &&
                 frac_act == $past(frac_sh))
        else $error("update strobe did not apply settings");
    a_sdm_bound: assert property ( // RQ15
        sdm_enable_out && $past(sdm_enable_out) && $stable(int_act) |->
        feedback_n_out == {1'b0, int_act} ||
        feedback_n_out == {1'b0, int_act} + N_ONE)
        else $error("modulated division outside integer..integer+1");
    a_reserved_zero: assert property ( // RQ16
        ack && read_in |=> readdata_out[31:8] == '0 &&
        ($past(idx) != IDX_FRAC_HIGH || readdata_out[7:4] == 4'h0))
        else $error("reserved bits read nonzero");
    c_frac_update: cover property (load && frac_sh != '0);
    c_carry: cover property (
        sdm_enable_out && feedback_n_out == {1'b0, int_act} + N_ONE);
    c_ref_double: cover property (ref_mode_out == REF_DOUBLE);
    c_status_read: cover property (ack && read_in && idx == IDX_STATUS);

endmodule

`default_nettype wire

// ==== logic/fdiv_pkg.sv ====
/*
 * Shared constants and types for the first synthesizer loop's frequency
 * translation control: register indices, field widths, reset values and
 * decode limits.
 * Assumes a byte address bus where each register index takes one word.
 */
`default_nettype none

package fdiv_pkg;

    // ************************************************************
    // Bus and field widths
    // ************************************************************
    localparam int unsigned ADDR_W   = 12;
    localparam int unsigned IDX_W    = ADDR_W - 2;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned BYTE_W   = 8;
    localparam int unsigned NIBBLE_W = 4;
    localparam int unsigned INT_W    = 8;
    localparam int unsigned FRAC_W   = 20;
    localparam int unsigned REFDIV_W = 12;
    localparam int unsigned SECDIV_W = 12;

    // ************************************************************
    // Register indices; the byte address is four times the index
    // ************************************************************
    localparam logic [IDX_W-1:0] IDX_UPDATE    = 10'h005;
    localparam logic [IDX_W-1:0] IDX_STATUS    = 10'h0F0;
    localparam logic [IDX_W-1:0] IDX_REF_LOW   = 10'h104;
    localparam logic [IDX_W-1:0] IDX_REF_HIGH  = 10'h105;
    localparam logic [IDX_W-1:0] IDX_INT       = 10'h106;
    localparam logic [IDX_W-1:0] IDX_FRAC_LOW  = 10'h107;
    localparam logic [IDX_W-1:0] IDX_FRAC_MID  = 10'h108;
    localparam logic [IDX_W-1:0] IDX_FRAC_HIGH = 10'h109;
    localparam logic [IDX_W-1:0] IDX_MOD_LOW   = 10'h10A;
    localparam logic [IDX_W-1:0] IDX_MOD_MID   = 10'h10B;
    localparam logic [IDX_W-1:0] IDX_MOD_HIGH  = 10'h10C;
    localparam logic [IDX_W-1:0] IDX_SEC_LOW   = 10'h10D;
    localparam logic [IDX_W-1:0] IDX_SEC_HIGH  = 10'h10E;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned UPDATE_BIT      = 0;
    localparam int unsigned STAT_FRAC_BIT   = 0;
    localparam int unsigned STAT_INT_OK_BIT = 1;
    localparam int unsigned STAT_MOD_OK_BIT = 2;
    localparam int unsigned STAT_LOOP2_BIT  = 3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [REFDIV_W-1:0] REF_DIV_RST = 12'h001;
    localparam logic [INT_W-1:0]    INT_RST     = 8'h0F;
    localparam logic [FRAC_W-1:0]   FRAC_RST    = 20'h00000;
    localparam logic [FRAC_W-1:0]   MOD_RST     = 20'h00001;
    localparam logic [SECDIV_W-1:0] SEC_DIV_RST = 12'h000;

    // ************************************************************
    // Decode limits
    // ************************************************************
    localparam logic [REFDIV_W-1:0] REF_DOUBLE_VAL = 12'h000;
    localparam logic [REFDIV_W-1:0] REF_BYPASS_MAX = 12'h003;
    localparam logic [SECDIV_W-1:0] SEC_BYPASS_MAX = 12'h001;
    localparam logic [SECDIV_W-1:0] SEC_UNDEF_MAX  = 12'h003;
    localparam logic [INT_W-1:0]    INT_MIN_INTN   = 8'h0F;
    localparam logic [INT_W-1:0]    INT_MIN_FRACN  = 8'h50;
    localparam logic [INT_W:0]      N_ONE          = 9'h001;

    typedef enum logic [1:0] {REF_DOUBLE, REF_BYPASS, REF_DIVIDE} ref_mode_t;
    typedef enum logic [1:0] {SEC_BYPASS, SEC_UNDEFINED, SEC_DIVIDE} sec_mode_t;

endpackage

`default_nettype wire

// ==== logic/sigma_delta_acc.sv ====
/*
 * First-order sigma-delta step for the primary feedback divider: each step
 * adds the fraction to an accumulator modulo the modulus and divides by the
 * integer part plus the carry.
 * Assumes modulus greater than fraction and a same-clock step pulse.
 */
`default_nettype none

module sigma_delta_acc #(
    parameter int unsigned INT_W  = 8,
    parameter int unsigned FRAC_W = 20
) (
    // Clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              rstn_in,
    // Control
    input  wire logic              run_in,
    input  wire logic              step_in,
    input  wire logic [INT_W-1:0]  int_in,
    input  wire logic [FRAC_W-1:0] frac_in,
    input  wire logic [FRAC_W-1:0] mod_in,
    // Result
    output var  logic [INT_W:0]    n_out,
    output var  logic              carry_out
);

    logic [FRAC_W-1:0] acc;
    logic [FRAC_W:0]   sum;
    logic              wrap;

    // RQ15: accumulate and wrap
    always_comb begin
        sum  = {1'b0, acc} + {1'b0, frac_in};
        wrap = (sum >= {1'b0, mod_in});
    end

    // A stopped modulator restarts from zero so phase never carries over.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc <= '0;
        end else if (!run_in) begin
            acc <= '0;
        end else if (step_in) begin
            acc <= wrap ? FRAC_W'(sum - {1'b0, mod_in}) : sum[FRAC_W-1:0];
        end
    end

    // RQ15: divide by integer plus carry
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            n_out     <= '0;
            carry_out <= 1'b0;
        end else if (!run_in) begin
            n_out     <= {1'b0, int_in};
            carry_out <= 1'b0;
        end else if (step_in) begin
            n_out     <= {1'b0, int_in} + {{INT_W{1'b0}}, wrap};
            carry_out <= wrap;
        end
    end

endmodule

`default_nettype wire

// ==== tb/pll_fractional_feedback_divider_tb.sv ====
/* Self-checking bench for the feedback divider control block.
   Assumes fdiv_pkg and the design module are compiled first. */
`default_nettype none
module pll_fractional_feedback_divider_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fdiv_pkg::*;
    logic              sys_clk_in;
    logic              rstn_in;
    logic [ADDR_W-1:0] address_in;
    logic              read_in;
    logic              write_in;
    logic [3:0]        byteenable_in;
    logic [DATA_W-1:0] writedata_in;
    logic [DATA_W-1:0] readdata_out;
    logic              waitrequest_out;
    logic              fb_step_in;
    ref_mode_t         ref_mode_out;
    logic [11:0]       ref_divisor_out;
    logic              sdm_enable_out;
    logic              int_legal_out;
    logic [8:0]        feedback_n_out;
    sec_mode_t         sec_mode_out;
    logic [11:0]       sec_divisor_out;
    logic              loop2_allowed_out;
    logic              update_out;
    logic [31:0]       q;
    int                n_errors = 0;
    int                checks = 0;
    int                cyc = 0;
    pll_fractional_feedback_divider u_dut (.sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in), .address_in(address_in), .read_in(read_in),
        .write_in(write_in), .byteenable_in(byteenable_in),
        .writedata_in(writedata_in), .readdata_out(readdata_out),
        .waitrequest_out(waitrequest_out), .fb_step_in(fb_step_in),
        .ref_mode_out(ref_mode_out), .ref_divisor_out(ref_divisor_out),
        .sdm_enable_out(sdm_enable_out), .int_legal_out(int_legal_out),
        .feedback_n_out(feedback_n_out), .sec_mode_out(sec_mode_out),
        .sec_divisor_out(sec_divisor_out),
        .loop2_allowed_out(loop2_allowed_out), .update_out(update_out));
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    task automatic report_and_stop();
        if (n_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // The ceiling is far above the few hundred cycles the tests need.
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    // Entered just after a rising edge; waitrequest and read data are
    // taken at the accepting edge, before that edge's own updates land.
    task automatic xfer(input logic w, input logic [9:0] idx,
                        input logic [7:0] d);
        address_in <= {idx, 2'b00};
        write_in <= w;
        read_in <= !w;
        writedata_in <= {24'h000000, d};
        do begin
            @(posedge sys_clk_in);
        end while (waitrequest_out !== 1'b0);
        q = readdata_out;
        write_in <= 1'b0;
        read_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
        xfer(1'b0, idx, 8'h00);
        chk(q, {24'h000000, e});
    endtask
    task automatic upd();
        xfer(1'b1, IDX_UPDATE, 8'h01);
        chk(32'(update_out), 32'h1);
        @(posedge sys_clk_in);
        chk(32'(update_out), 32'h0);
    endtask
    task automatic t_reset();
        rdc(IDX_INT, 8'h0F);
        rdc(IDX_FRAC_HIGH, 8'h00);
        rdc(IDX_MOD_LOW, 8'h01);
        rdc(10'h3FF, 8'h00);
        rdc(IDX_UPDATE, 8'h00);
    endtask
    task automatic t_reserved();
        logic [9:0] hi[4] = '{IDX_REF_HIGH, IDX_FRAC_HIGH, IDX_MOD_HIGH,
                              IDX_SEC_HIGH};
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, hi[i], 8'hFF);
            rdc(hi[i], 8'h0F);
            xfer(1'b1, hi[i], 8'h00);
        end
        byteenable_in <= 4'h0;
        xfer(1'b1, IDX_INT, 8'hAA);
        byteenable_in <= 4'h1;
        rdc(IDX_INT, 8'h0F);
    endtask
    task automatic t_predivider();
        logic [11:0] v[4] = '{12'h000, 12'h003, 12'h004, 12'hFFF};
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, IDX_REF_LOW, v[i][7:0]);
            xfer(1'b1, IDX_REF_HIGH, {4'h0, v[i][11:8]});
            upd();
            chk(32'(ref_mode_out), (i == 0) ? 32'(REF_DOUBLE) :
                (i == 1) ? 32'(REF_BYPASS) : 32'(REF_DIVIDE));
            chk(32'(ref_divisor_out), 32'(v[i]));
            @(posedge sys_clk_in);
        end
    endtask
    task automatic t_integer();
        logic [7:0] v[3] = '{8'h0E, 8'h0F, 8'hFF};
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, IDX_INT, v[i]);
            upd();
            chk(32'(int_legal_out), 32'(i != 0));
            chk(32'(sdm_enable_out), 32'h0);
            chk(32'(feedback_n_out), 32'(v[i]));
            @(posedge sys_clk_in);
        end
    endtask
    task automatic t_fraction();
        xfer(1'b1, IDX_MOD_LOW, 8'h04);
        xfer(1'b1, IDX_FRAC_LOW, 8'h01);
        xfer(1'b1, IDX_INT, 8'h4F);
        upd();
        chk(32'(sdm_enable_out), 32'h1);
        chk(32'(int_legal_out), 32'h0);
        @(posedge sys_clk_in);
        xfer(1'b1, IDX_INT, 8'h50);
        upd();
        chk(32'(int_legal_out), 32'h1);
        rdc(IDX_STATUS, 8'h07);
        fb_step_in <= 1'b1;
        @(posedge sys_clk_in);
        for (int k = 0; k < 4; k++) begin
            if (k == 3) fb_step_in <= 1'b0;
            @(posedge sys_clk_in);
            chk(32'(feedback_n_out), (k == 3) ? 32'd81 : 32'd80);
        end
        @(posedge sys_clk_in);
    endtask
    task automatic t_secondary();
        logic [7:0] v[4] = '{8'h00, 8'h01, 8'h02, 8'h04};
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, IDX_SEC_LOW, v[i]);
            upd();
            chk(32'(sec_mode_out), (i < 2) ? 32'(SEC_BYPASS) : (i == 2) ?
                32'(SEC_UNDEFINED) : 32'(SEC_DIVIDE));
            chk(32'(loop2_allowed_out), 32'(i >= 2));
            chk(32'(sec_divisor_out), 32'(v[i]));
            @(posedge sys_clk_in);
        end
    endtask
    initial begin
        rstn_in = 1'b0;
        address_in = '0;
        read_in = 1'b0;
        write_in = 1'b0;
        byteenable_in = 4'h1;
        writedata_in = '0;
        fb_step_in = 1'b0;
        repeat (16) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        @(posedge sys_clk_in);
        t_reset();
        t_reserved();
        t_predivider();
        t_integer();
        t_fraction();
        t_secondary();
        report_and_stop();
    end
endmodule
`default_nettype wire
